// File: rtl/cies_pkg.sv
// Shared constants and types for the instruction execution subset
package cies_pkg;

	localparam int          CIES_DATA_W     = 8;
	localparam int          CIES_FADDR_W    = 7;
	localparam int          CIES_PC_W       = 15;
	localparam int          CIES_ADDR_W     = 8;

	// Register port map; file registers occupy offsets 0x00 to 0x7f
	localparam logic [7:0]  CIES_OFS_FILE_MAX = 8'h7f;
	localparam logic [7:0]  CIES_OFS_ACC      = 8'h80;
	localparam logic [7:0]  CIES_OFS_STATUS   = 8'h81;
	localparam logic [7:0]  CIES_OFS_LATCH    = 8'h82;
	localparam logic [7:0]  CIES_OFS_PC_LO    = 8'h83;
	localparam logic [7:0]  CIES_OFS_PC_HI    = 8'h84;
	localparam logic [7:0]  CIES_OFS_WDOG     = 8'h85;
	localparam logic [7:0]  CIES_OFS_PRESC    = 8'h86;
	localparam logic [7:0]  CIES_OFS_STK_HEAD = 8'h87;
	localparam logic [7:0]  CIES_OFS_STK_PTR  = 8'h88;

	// Status bit positions
	localparam int          CIES_ST_ZERO    = 2;
	localparam int          CIES_ST_SLEEP   = 3;
	localparam int          CIES_ST_EXPIRY  = 4;

	// Values after reset
	localparam logic [7:0]  CIES_RST_STATUS = 8'h18;
	localparam logic [7:0]  CIES_RST_BYTE   = 8'h00;
	localparam logic [14:0] CIES_RST_PC     = 15'h0000;
	localparam logic [7:0]  CIES_WDOG_CLEAR = 8'h00;

	// Cycle counts
	localparam int          CIES_CALL_CYCLES = 2;
	localparam int          CIES_SKIP_CYCLES = 2;

	typedef enum logic [2:0]
	{
		CIES_OP_NOP,
		CIES_OP_CLEAR_WATCHDOG,
		CIES_OP_CALL_VIA_ACC,
		CIES_OP_COMPLEMENT_FILE,
		CIES_OP_CLEAR_FILE,
		CIES_OP_CLEAR_ACC,
		CIES_OP_DECREMENT_FILE,
		CIES_OP_DECREMENT_SKIP
	} cies_opcode_t;

	typedef struct packed
	{
		cies_opcode_t           opcode;
		logic [CIES_FADDR_W-1:0] faddr;
		logic                    dest;
	} cies_req_t;

	typedef struct packed
	{
		logic [CIES_ADDR_W-1:0] addr;
		logic [CIES_DATA_W-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} cies_bus_t;

endpackage

// File: rtl/cies_core.sv
// Execution unit for a subset of the core instruction set
//
// What this block does
// - Watchdog clear loads the watchdog counter with zero.
// - Watchdog clear also zeroes prescaler, sets sleep flag, sets expiry unless a timeout lands in that cycle.
// - Accumulator call pushes PC plus one onto return stack first.
// - Call loads PC low from accumulator, PC high from latch bits 6..0.
// - Accumulator call takes two cycles, leaves status flags unchanged.
// - Complement inverts file register; dest 0 to accumulator, 1 to file.
// - File clear writes zero to addressed file register, sets zero flag.
// - Accumulator clear writes zero to accumulator, sets zero flag.
// - Decrement subtracts one; dest selects target; zero flag updated.
// - Decrement-and-skip writes result to destination, flags unchanged.
// - Zero result discards next instruction as a no-op, two cycles.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps

module cies_core
	import cies_pkg::*;
#(
	parameter int PRESC_W     = 8,
	parameter int STACK_DEPTH = 16,
	parameter int STACK_PTR_W = 4
)
(
	input  wire logic                   CORE_CLK,
	input  wire logic                   NRST,
	input  wire logic                   OP_VALID,
	input  wire cies_req_t              OP_REQ,
	output logic                        OP_READY,
	output logic                        OP_DONE,
	output logic                        OP_SKIP,
	input  wire cies_bus_t              REG_BUS,
	output logic [CIES_DATA_W-1:0]      REG_RDATA,
	output logic [CIES_PC_W-1:0]        PC_OUT,
	output logic                        WDOG_TIMEOUT
);

	typedef enum logic [1:0]
	{
		CIES_ST_IDLE,
		CIES_ST_SECOND,
		CIES_ST_NOP
	} cies_state_t;

	logic                     rst_s1_reg;
	logic                     rst_n_reg;
	cies_state_t              state_reg;
	logic [CIES_DATA_W-1:0]   file_mem [0:127];
	logic [CIES_DATA_W-1:0]   acc_reg;
	logic [CIES_DATA_W-1:0]   status_reg;
	logic [CIES_DATA_W-1:0]   latch_reg;
	logic [CIES_PC_W-1:0]     pc_reg;
	logic [CIES_PC_W-1:0]     stack_mem [0:STACK_DEPTH-1];
	logic [STACK_PTR_W-1:0]   sp_reg;
	logic [CIES_DATA_W-1:0]   wdog_reg;
	logic [PRESC_W-1:0]       presc_reg;
	logic [CIES_DATA_W-1:0]   rdata_reg;
	logic                     done_reg;
	logic                     skip_reg;
	logic                     timeout_reg;

	logic                     take;
	logic [CIES_DATA_W-1:0]   file_q;
	logic [CIES_DATA_W-1:0]   dec_res;
	logic [CIES_DATA_W-1:0]   com_res;
	logic [CIES_DATA_W-1:0]   res;
	logic                     res_zero;
	logic                     to_file;
	logic                     to_acc;
	logic                     bus_file_wr;
	logic [STACK_PTR_W-1:0]   sp_top;

	// Reset release through two flops
	always_ff @(posedge CORE_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			rst_s1_reg <= 1'b0;
			rst_n_reg  <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_n_reg  <= rst_s1_reg;
		end
	end

	// New request only taken while no two-cycle op is finishing
	assign OP_READY = (state_reg == CIES_ST_IDLE);
	assign take     = OP_VALID && OP_READY;
	assign file_q   = file_mem[OP_REQ.faddr];
	assign dec_res  = file_q - 8'h01;
	assign com_res  = ~file_q;
	assign sp_top   = sp_reg - 1'b1;

	always_comb
	begin
		res     = CIES_RST_BYTE;
		to_file = 1'b0;
		to_acc  = 1'b0;
		if (take)
		begin
			case (OP_REQ.opcode)
				CIES_OP_COMPLEMENT_FILE:
				begin
					res     = com_res;
					to_file = OP_REQ.dest;
					to_acc  = !OP_REQ.dest;
				end
				CIES_OP_CLEAR_FILE:
				begin
					res     = CIES_RST_BYTE;
					to_file = 1'b1;
				end
				CIES_OP_CLEAR_ACC:
				begin
					res    = CIES_RST_BYTE;
					to_acc = 1'b1;
				end
				CIES_OP_DECREMENT_FILE, CIES_OP_DECREMENT_SKIP:
				begin
					res     = dec_res;
					to_file = OP_REQ.dest;
					to_acc  = !OP_REQ.dest;
				end
				default:
				begin
					res     = CIES_RST_BYTE;
					to_file = 1'b0;
					to_acc  = 1'b0;
				end
			endcase
		end
	end

	assign res_zero    = (res == CIES_RST_BYTE);
	assign bus_file_wr = REG_BUS.wr && (REG_BUS.addr <= CIES_OFS_FILE_MAX);

	// File registers; execution write wins over a port write
	always_ff @(posedge CORE_CLK)
	begin
		if (bus_file_wr)
			file_mem[REG_BUS.addr[6:0]] <= REG_BUS.wdata;
		if (to_file)
			file_mem[OP_REQ.faddr] <= res;
	end

	// Accumulator
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			acc_reg <= CIES_RST_BYTE;
		else if (to_acc)
			acc_reg <= res;
		else if (REG_BUS.wr && REG_BUS.addr == CIES_OFS_ACC)
			acc_reg <= REG_BUS.wdata;
	end

	// Upper address latch, only bits 6..0 reach the PC
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			latch_reg <= CIES_RST_BYTE;
		else if (REG_BUS.wr && REG_BUS.addr == CIES_OFS_LATCH)
			latch_reg <= REG_BUS.wdata;
	end

	// Status: zero flag and the two reset-cause flags
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			status_reg <= CIES_RST_STATUS;
		else
		begin
			if (REG_BUS.wr && REG_BUS.addr == CIES_OFS_STATUS)
				status_reg[CIES_ST_ZERO] <= REG_BUS.wdata[CIES_ST_ZERO];
			if (take)
			begin
				case (OP_REQ.opcode)
					CIES_OP_CLEAR_WATCHDOG:
					begin
						status_reg[CIES_ST_EXPIRY] <= 1'b1;
						status_reg[CIES_ST_SLEEP]  <= 1'b1;
					end
					CIES_OP_CLEAR_FILE, CIES_OP_CLEAR_ACC:
						status_reg[CIES_ST_ZERO] <= 1'b1;
					CIES_OP_COMPLEMENT_FILE, CIES_OP_DECREMENT_FILE:
						status_reg[CIES_ST_ZERO] <= res_zero;
					// call and skip touch no flags
					default: ;
				endcase
			end
			// Expiry is active low; a timeout beats a clear in one cycle
			if (timeout_reg)
				status_reg[CIES_ST_EXPIRY] <= 1'b0;
		end
	end

	// Sequencer for second cycles
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			state_reg <= CIES_ST_IDLE;
		else
		begin
			case (state_reg)
				CIES_ST_IDLE:
				begin
					if (take && OP_REQ.opcode == CIES_OP_CALL_VIA_ACC)
						state_reg <= CIES_ST_SECOND;
					// zero result runs a no-op slot
					else if (take && OP_REQ.opcode == CIES_OP_DECREMENT_SKIP && res_zero)
						state_reg <= CIES_ST_NOP;
				end
				CIES_ST_SECOND, CIES_ST_NOP:
					state_reg <= CIES_ST_IDLE;
				default:
					state_reg <= CIES_ST_IDLE;
			endcase
		end
	end

	// Completion pulse comes in the cycle after the last cycle of each op
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			done_reg <= 1'b0;
			skip_reg <= 1'b0;
		end
		else
		begin
			done_reg <= (take && OP_REQ.opcode != CIES_OP_CALL_VIA_ACC
				&& !(OP_REQ.opcode == CIES_OP_DECREMENT_SKIP && res_zero))
				|| state_reg != CIES_ST_IDLE;
			skip_reg <= (state_reg == CIES_ST_NOP);
		end
	end

	// Program counter and return stack
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			pc_reg <= CIES_RST_PC;
			sp_reg <= '0;
		end
		else if (take && OP_REQ.opcode == CIES_OP_CALL_VIA_ACC)
		begin
			// push return address, old PC used
			stack_mem[sp_reg] <= pc_reg + 15'h0001;
			sp_reg            <= sp_reg + 1'b1;
			pc_reg            <= {latch_reg[6:0], acc_reg};
		end
		else if (take || state_reg == CIES_ST_NOP)
			// the discarded slot still advances PC
			pc_reg <= pc_reg + 15'h0001;
		else if (REG_BUS.wr && REG_BUS.addr == CIES_OFS_PC_LO)
			pc_reg[7:0] <= REG_BUS.wdata;
		else if (REG_BUS.wr && REG_BUS.addr == CIES_OFS_PC_HI)
			pc_reg[14:8] <= REG_BUS.wdata[6:0];
	end

	// Watchdog: prescaler wraps then counter steps
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			presc_reg   <= '0;
			wdog_reg    <= CIES_WDOG_CLEAR;
			timeout_reg <= 1'b0;
		end
		else if (take && OP_REQ.opcode == CIES_OP_CLEAR_WATCHDOG)
		begin
			wdog_reg    <= CIES_WDOG_CLEAR;
			presc_reg   <= '0;
			timeout_reg <= 1'b0;
		end
		else
		begin
			presc_reg   <= presc_reg + 1'b1;
			timeout_reg <= 1'b0;
			if (&presc_reg)
			begin
				wdog_reg    <= wdog_reg + 8'h01;
				timeout_reg <= &wdog_reg;
			end
		end
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge CORE_CLK or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			rdata_reg <= CIES_RST_BYTE;
		else if (REG_BUS.rd)
		begin
			if (REG_BUS.addr <= CIES_OFS_FILE_MAX)
				rdata_reg <= file_mem[REG_BUS.addr[6:0]];
			else
			begin
				case (REG_BUS.addr)
					CIES_OFS_ACC:      rdata_reg <= acc_reg;
					CIES_OFS_STATUS:   rdata_reg <= status_reg;
					CIES_OFS_LATCH:    rdata_reg <= latch_reg;
					CIES_OFS_PC_LO:    rdata_reg <= pc_reg[7:0];
					CIES_OFS_PC_HI:    rdata_reg <= {1'b0, pc_reg[14:8]};
					CIES_OFS_WDOG:     rdata_reg <= wdog_reg;
					CIES_OFS_PRESC:    rdata_reg <= 8'(presc_reg);
					CIES_OFS_STK_HEAD: rdata_reg <= stack_mem[sp_top][7:0];
					CIES_OFS_STK_PTR:  rdata_reg <= {{(8-STACK_PTR_W){1'b0}}, sp_reg};
					default:           rdata_reg <= CIES_RST_BYTE;
				endcase
			end
		end
		else
			rdata_reg <= CIES_RST_BYTE;
	end

	assign OP_DONE      = done_reg;
	assign OP_SKIP      = skip_reg;
	assign REG_RDATA    = rdata_reg;
	assign PC_OUT       = pc_reg;
	assign WDOG_TIMEOUT = timeout_reg;

endmodule

// File: verif/cies_core_properties.sv
// Port timing checks for the execution unit
`timescale 1ns/1ps
module cies_core_checker
	import cies_pkg::*;
(
	input wire logic                 CORE_CLK,
	input wire logic                 NRST,
	input wire logic                 OP_VALID,
	input wire cies_req_t            OP_REQ,
	input wire logic                 OP_READY,
	input wire logic                 OP_DONE,
	input wire logic                 OP_SKIP,
	input wire logic [CIES_PC_W-1:0] PC_OUT,
	input wire logic                 WDOG_TIMEOUT
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	wire take = OP_VALID && OP_READY;
	wire is_call = OP_REQ.opcode == CIES_OP_CALL_VIA_ACC;
	wire is_dsk = OP_REQ.opcode == CIES_OP_DECREMENT_SKIP;
	wire is_one = !is_call && !is_dsk && OP_REQ.opcode != CIES_OP_NOP;

	call_two_cycle_a: assert property (take && is_call |=> !OP_READY ##1 OP_DONE && OP_READY)
		else $error("call timing wrong");
	call_pc_hold_a: assert property (take && is_call |=> ##1 $stable(PC_OUT))
		else $error("call target not held");
	single_done_a: assert property (take && is_one |=> OP_DONE && OP_READY && !OP_SKIP
		&& PC_OUT == $past(PC_OUT) + 15'h1)
		else $error("single op timing wrong");
	skip_pair_a: assert property (OP_SKIP |-> OP_DONE)
		else $error("skip without done");
	skip_pc_a: assert property (take && is_dsk ##1 !OP_READY |=> OP_SKIP
		&& PC_OUT == $past(PC_OUT, 2) + 15'h2)
		else $error("skip slot wrong");
	skip_short_a: assert property (take && is_dsk ##1 OP_READY |-> OP_DONE && !OP_SKIP)
		else $error("nonzero skip wrong");
	wdog_quiet_a: assert property (take && OP_REQ.opcode == CIES_OP_CLEAR_WATCHDOG
		|=> !WDOG_TIMEOUT [*8])
		else $error("timeout after clear");
	stall_cause_a: assert property (!OP_READY |-> $past(take) && $past(is_call || is_dsk))
		else $error("stall without cause");
	stall_end_a: assert property (!OP_READY |=> OP_DONE && OP_READY)
		else $error("second cycle not ended");
endmodule

bind cies_core cies_core_checker cies_core_checker_i (.CORE_CLK, .NRST, .OP_VALID, .OP_REQ,
	.OP_READY, .OP_DONE, .OP_SKIP, .PC_OUT, .WDOG_TIMEOUT);

// File: verif/cies_core_tb.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module cies_core_tb
	import cies_pkg::*;
;
	logic        CORE_CLK = 1'b0;
	logic        NRST     = 1'b0;
	logic        OP_VALID = 1'b0;
	cies_req_t   OP_REQ   = '0;
	cies_bus_t   REG_BUS  = '0;
	logic        OP_READY, OP_DONE, OP_SKIP, WDOG_TIMEOUT, skp;
	logic [7:0]  REG_RDATA, rdv;
	logic [14:0] PC_OUT, pc0;
	int          fail_count = 0, cmp_count = 0, cyc;

	always #5 CORE_CLK = ~CORE_CLK;

	// Short prescaler keeps the watchdog wrap inside the run
	cies_core #(.PRESC_W(2)) cies_core_i (.CORE_CLK, .NRST, .OP_VALID, .OP_REQ, .OP_READY,
		.OP_DONE, .OP_SKIP, .REG_BUS, .REG_RDATA, .PC_OUT, .WDOG_TIMEOUT);

	task automatic chk(logic [14:0] s, logic [14:0] e);
		cmp_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		REG_BUS <= '{a, d, 1'b1, 1'b0};
		@(posedge CORE_CLK);
		REG_BUS <= '0;
		@(posedge CORE_CLK);
	endtask

	// Read data sampled mid-cycle, while it stands
	task automatic rd(logic [7:0] a);
		REG_BUS <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge CORE_CLK);
		REG_BUS <= '0;
		@(negedge CORE_CLK);
		rdv = REG_RDATA;
		@(posedge CORE_CLK);
	endtask

	task automatic op(cies_opcode_t o, logic [6:0] f, logic d, int n);
		pc0 = PC_OUT;
		OP_VALID <= 1'b1;
		OP_REQ <= '{o, f, d};
		@(posedge CORE_CLK);
		OP_VALID <= 1'b0;
		cyc = 0;
		do
		begin
			@(negedge CORE_CLK);
			cyc++;
		end
		while (OP_DONE !== 1'b1 && cyc < 4);
		skp = OP_SKIP;
		@(posedge CORE_CLK);
		chk(15'(cyc), 15'(n));
	endtask

	task automatic t_clear;
		wr(8'h7f, 8'h3c);
		wr(CIES_OFS_STATUS, 8'h00);
		op(CIES_OP_CLEAR_FILE, 7'h7f, 1'b0, 1);
		rd(8'h7f);
		chk(rdv, 8'h00);
		rd(CIES_OFS_STATUS);
		chk(rdv[2], 1'b1);
		wr(CIES_OFS_ACC, 8'h55);
		wr(CIES_OFS_STATUS, 8'h00);
		op(CIES_OP_CLEAR_ACC, 7'h00, 1'b0, 1);
		rd(CIES_OFS_ACC);
		chk(rdv, 8'h00);
		rd(CIES_OFS_STATUS);
		chk(rdv[2], 1'b1);
		$display("clear test done");
	endtask

	task automatic t_comp_dec;
		wr(8'h7e, 8'ha5);
		wr(CIES_OFS_STATUS, 8'h04);
		op(CIES_OP_COMPLEMENT_FILE, 7'h7e, 1'b0, 1);
		rd(CIES_OFS_ACC);
		chk(rdv, 8'h5a);
		rd(CIES_OFS_STATUS);
		chk(rdv[2], 1'b0);
		op(CIES_OP_COMPLEMENT_FILE, 7'h7e, 1'b1, 1);
		rd(8'h7e);
		chk(rdv, 8'h5a);
		wr(8'h10, 8'h01);
		op(CIES_OP_DECREMENT_FILE, 7'h10, 1'b0, 1);
		rd(CIES_OFS_ACC);
		chk(rdv, 8'h00);
		rd(CIES_OFS_STATUS);
		chk(rdv[2], 1'b1);
		op(CIES_OP_DECREMENT_FILE, 7'h10, 1'b1, 1);
		op(CIES_OP_DECREMENT_FILE, 7'h10, 1'b1, 1);
		rd(8'h10);
		chk(rdv, 8'hff);
		rd(CIES_OFS_STATUS);
		chk(rdv[2], 1'b0);
		$display("complement test done");
	endtask

	task automatic t_skip;
		wr(8'h20, 8'h02);
		wr(CIES_OFS_STATUS, 8'h00);
		op(CIES_OP_DECREMENT_SKIP, 7'h20, 1'b1, 1);
		chk(skp, 1'b0);
		chk(PC_OUT, pc0 + 15'h1);
		op(CIES_OP_DECREMENT_SKIP, 7'h20, 1'b0, 2);
		chk(skp, 1'b1);
		chk(PC_OUT, pc0 + 15'h2);
		rd(CIES_OFS_ACC);
		chk(rdv, 8'h00);
		rd(8'h20);
		chk(rdv, 8'h01);
		rd(CIES_OFS_STATUS);
		chk(rdv[2], 1'b0);
		$display("skip test done");
	endtask

	task automatic t_call;
		wr(CIES_OFS_ACC, 8'h34);
		wr(CIES_OFS_LATCH, 8'hd2);
		wr(CIES_OFS_PC_LO, 8'h10);
		wr(CIES_OFS_PC_HI, 8'h00);
		wr(CIES_OFS_STATUS, 8'h04);
		op(CIES_OP_CALL_VIA_ACC, 7'h00, 1'b0, 2);
		chk(PC_OUT, {7'h52, 8'h34});
		rd(CIES_OFS_STK_HEAD);
		chk(rdv, 8'h11);
		rd(CIES_OFS_STATUS);
		chk(rdv[2], 1'b1);
		$display("call test done");
	endtask

	task automatic t_wdog;
		cyc = 0;
		while (WDOG_TIMEOUT !== 1'b1 && cyc < 1500)
		begin
			@(posedge CORE_CLK);
			cyc++;
		end
		rd(CIES_OFS_STATUS);
		chk(rdv[4], 1'b0);
		// Let the counter move off zero so the clear is visible
		repeat (20) @(posedge CORE_CLK);
		op(CIES_OP_CLEAR_WATCHDOG, 7'h00, 1'b0, 1);
		rd(CIES_OFS_PRESC);
		chk(rdv, 8'h01);
		rd(CIES_OFS_WDOG);
		chk(rdv, 8'h00);
		rd(CIES_OFS_STATUS);
		chk(rdv[4:3], 2'b11);
		$display("watchdog test done");
	endtask

	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		#100000;
		fail_count++;
		close_out();
	end

	initial
	begin
		repeat (10) @(posedge CORE_CLK);
		NRST <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		t_clear();
		t_comp_dec();
		t_skip();
		t_call();
		t_wdog();
		close_out();
	end
endmodule
